// ---- verilog/iosd_defs.vh ----
// Constants for the peripheral register space decoder.
//
// Functional notes
// RULE1: Software writes zero to reserved bits; hardware also keeps them at zero.
// RULE2: Software never writes reserved addresses; such writes are refused and flagged.
// RULE3: Single-bit set and clear work only on I/O addresses 0x00 to 0x1F.
// RULE4: Low-range bits can be tested, requesting a skip when set or clear.
// RULE5: Some status flags clear on a written one; a written zero leaves them.
// RULE6: Bit set or clear touches only the addressed bit, sparing other flags.
// RULE7: Short I/O accesses use I/O addresses 0x00 to 0x3F.
// RULE8: Data-space address equals I/O address plus 0x20.
// RULE9: Extended range 0x60 to 0xFF is reachable only by data-space load and store.
// RULE10: Each extended address selects one register; reserved reads return zero, no effects.
`ifndef IOSD_DEFS_VH
`define IOSD_DEFS_VH

// ****************************************
// Core access operation codes.
// ****************************************
`define IOSD_OP_IO_READ 3'h0
`define IOSD_OP_IO_WRITE 3'h1
`define IOSD_OP_SET_BIT 3'h2
`define IOSD_OP_CLEAR_BIT 3'h3
`define IOSD_OP_SKIP_HIGH 3'h4
`define IOSD_OP_SKIP_LOW 3'h5
`define IOSD_OP_DATA_LOAD 3'h6
`define IOSD_OP_DATA_STORE 3'h7

// ****************************************
// Address ranges.
// ****************************************
`define IOSD_IO_TO_DATA 8'h20
`define IOSD_DATA_IO_FIRST 8'h20
`define IOSD_DATA_IO_LAST 8'h5F
`define IOSD_EXT_FIRST 8'h60
`define IOSD_EXT_LAST 8'hFF
`define IOSD_BIT_IO_LAST 6'h1F
`define IOSD_SHORT_IO_LAST 6'h3F
`define IOSD_RST_VAL 8'h00

// ****************************************
// Low-range flag registers (data-space addresses).
// ****************************************
`define IOSD_TMR0_FLAGS 8'h35
`define IOSD_TMR1_FLAGS 8'h36
`define IOSD_TMR2_FLAGS 8'h37
`define IOSD_PCHG_FLAGS 8'h3B
`define IOSD_EXT_FLAGS 8'h3C

// ****************************************
// Extended register offsets.
// ****************************************
`define IOSD_PIN_CHANGE_MASK_0 8'h6B
`define IOSD_PIN_CHANGE_MASK_1 8'h6C
`define IOSD_PIN_CHANGE_MASK_2 8'h6D
`define IOSD_TIMER0_IRQ_ENABLES 8'h6E
`define IOSD_TIMER1_IRQ_ENABLES 8'h6F
`define IOSD_TIMER2_IRQ_ENABLES 8'h70
`define IOSD_CONVERTER_RESULT_LOW 8'h78
`define IOSD_CONVERTER_CONTROL_STATUS_A 8'h7A
`define IOSD_CONVERTER_CONTROL_STATUS_B 8'h7B
`define IOSD_CONVERTER_INPUT_SELECT 8'h7C
`define IOSD_DIGITAL_INPUT_DISABLE_0 8'h7E
`define IOSD_DIGITAL_INPUT_DISABLE_1 8'h7F
`define IOSD_WIDE_TIMER_CONTROL_A 8'h80
`define IOSD_WIDE_TIMER_CONTROL_B 8'h81
`define IOSD_WIDE_TIMER_CONTROL_C 8'h82
`define IOSD_WIDE_TIMER_COUNT_LOW 8'h84
`define IOSD_WIDE_TIMER_COUNT_HIGH 8'h85
`define IOSD_WIDE_TIMER_CAPTURE_LOW 8'h86
`define IOSD_WIDE_TIMER_CAPTURE_HIGH 8'h87
`define IOSD_WIDE_TIMER_COMPARE_A_LOW 8'h88
`define IOSD_WIDE_TIMER_COMPARE_A_HIGH 8'h89
`define IOSD_WIDE_TIMER_COMPARE_B_LOW 8'h8A
`define IOSD_WIDE_TIMER_COMPARE_B_HIGH 8'h8B
`define IOSD_ASYNC_TIMER_CONTROL_A 8'hB0
`define IOSD_ASYNC_TIMER_CONTROL_B 8'hB1
`define IOSD_ASYNC_TIMER_COUNT 8'hB2
`define IOSD_ASYNC_TIMER_COMPARE_A 8'hB3
`define IOSD_ASYNC_TIMER_COMPARE_B 8'hB4
`define IOSD_ASYNC_TIMER_STATUS 8'hB6
`define IOSD_TWO_WIRE_BIT_RATE 8'hB8
`define IOSD_TWO_WIRE_STATUS 8'hB9
`define IOSD_TWO_WIRE_OWN_ADDRESS 8'hBA
`define IOSD_TWO_WIRE_DATA 8'hBB
`define IOSD_TWO_WIRE_CONTROL 8'hBC
`define IOSD_TWO_WIRE_ADDRESS_MASK 8'hBD
`define IOSD_SERIAL_PORT_STATUS_A 8'hC0
`define IOSD_SERIAL_PORT_CONTROL_B 8'hC1
`define IOSD_SERIAL_PORT_CONTROL_C 8'hC2
`define IOSD_SERIAL_BAUD_LOW 8'hC4
`define IOSD_SERIAL_BAUD_HIGH 8'hC5
`define IOSD_SERIAL_DATA_BUFFER 8'hC6

// ****************************************
// Field masks: write-one-to-clear flags.
// ****************************************
`define IOSD_W1C_TMR_FLAGS 8'h07
`define IOSD_W1C_TMR1_FLAGS 8'h27
`define IOSD_W1C_PCHG_FLAGS 8'h07
`define IOSD_W1C_EXT_FLAGS 8'h03
`define IOSD_W1C_CONV_DONE 8'h10
`define IOSD_W1C_TWI_INT 8'h80
`define IOSD_W1C_SER_TXDONE 8'h40

// ****************************************
// Field masks: hardware-owned (read-only) bits.
// ****************************************
`define IOSD_RO_ALL 8'hFF
`define IOSD_RO_ASYNC_BUSY 8'h1F
`define IOSD_RO_TWI_STATE 8'hF8
`define IOSD_RO_TWI_COLL 8'h08
`define IOSD_RO_SER_STAT 8'hBC
`define IOSD_RO_SER_RX9 8'h02

// ****************************************
// Field masks: reserved bits.
// ****************************************
`define IOSD_RSV_PCM1 8'h80
`define IOSD_RSV_TMSK 8'hF8
`define IOSD_RSV_TMSK1 8'hD8
`define IOSD_RSV_CONV_SEL 8'h10
`define IOSD_RSV_DIDIS1 8'hFC
`define IOSD_RSV_WT_CTLA 8'h0C
`define IOSD_RSV_WT_CTLB 8'h20
`define IOSD_RSV_WT_CTLC 8'h3F
`define IOSD_RSV_AT_CTLB 8'h30
`define IOSD_RSV_AT_STAT 8'h80
`define IOSD_RSV_TWI_STAT 8'h04
`define IOSD_RSV_TWI_CTL 8'h02
`define IOSD_RSV_TWI_AMSK 8'h01
`define IOSD_RSV_BAUD_HI 8'hF0

`endif

// ---- verilog/iosd_decoder.v ----
// Peripheral register space decoder with bit access and flag handling.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defs.vh"

module iosd_decoder (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire acc_valid_i,
	input wire [2:0] acc_op_i,
	input wire [7:0] acc_addr_i,
	input wire [2:0] acc_bit_i,
	input wire [7:0] acc_wdata_i,
	input wire hw_load_i,
	input wire hw_set_i,
	input wire [7:0] hw_addr_i,
	input wire [7:0] hw_data_i,
	output reg ack_o,
	output reg [7:0] rdata_o,
	output reg skip_o,
	output reg err_o,
	output reg wr_stb_o,
	output reg [7:0] wr_addr_o,
	output reg [7:0] wr_data_o
);

	// ****************************************
	// Address map functions.
	// ****************************************

	// Converts a short I/O address to its data-space address.
	// Only short and bit ops pass through this offset; loads and stores carry data addresses.
	function [7:0] io_to_data;
		input [5:0] io;
		begin
			io_to_data = {2'h0, io} + `IOSD_IO_TO_DATA; // see RULE8
		end
	endfunction

	// True when a data-space address holds a register; each hit names exactly one entry.
	function is_mapped;
		input [7:0] a;
		begin
			// The whole low range counts as mapped; its gaps are left to the peripherals behind it.
			if (a >= `IOSD_DATA_IO_FIRST && a <= `IOSD_DATA_IO_LAST) begin
				is_mapped = 1'b1;
			end else begin
				case (a) // see RULE10
				`IOSD_PIN_CHANGE_MASK_0,
				`IOSD_PIN_CHANGE_MASK_1,
				`IOSD_PIN_CHANGE_MASK_2,
				`IOSD_TIMER0_IRQ_ENABLES,
				`IOSD_TIMER1_IRQ_ENABLES,
				`IOSD_TIMER2_IRQ_ENABLES,
				`IOSD_CONVERTER_RESULT_LOW,
				`IOSD_CONVERTER_CONTROL_STATUS_A,
				`IOSD_CONVERTER_CONTROL_STATUS_B,
				`IOSD_CONVERTER_INPUT_SELECT,
				`IOSD_DIGITAL_INPUT_DISABLE_0,
				`IOSD_DIGITAL_INPUT_DISABLE_1,
				`IOSD_WIDE_TIMER_CONTROL_A,
				`IOSD_WIDE_TIMER_CONTROL_B,
				`IOSD_WIDE_TIMER_CONTROL_C,
				`IOSD_WIDE_TIMER_COUNT_LOW,
				`IOSD_WIDE_TIMER_COUNT_HIGH,
				`IOSD_WIDE_TIMER_CAPTURE_LOW,
				`IOSD_WIDE_TIMER_CAPTURE_HIGH,
				`IOSD_WIDE_TIMER_COMPARE_A_LOW,
				`IOSD_WIDE_TIMER_COMPARE_A_HIGH,
				`IOSD_WIDE_TIMER_COMPARE_B_LOW,
				`IOSD_WIDE_TIMER_COMPARE_B_HIGH,
				`IOSD_ASYNC_TIMER_CONTROL_A,
				`IOSD_ASYNC_TIMER_CONTROL_B,
				`IOSD_ASYNC_TIMER_COUNT,
				`IOSD_ASYNC_TIMER_COMPARE_A,
				`IOSD_ASYNC_TIMER_COMPARE_B,
				`IOSD_ASYNC_TIMER_STATUS,
				`IOSD_TWO_WIRE_BIT_RATE,
				`IOSD_TWO_WIRE_STATUS,
				`IOSD_TWO_WIRE_OWN_ADDRESS,
				`IOSD_TWO_WIRE_DATA,
				`IOSD_TWO_WIRE_CONTROL,
				`IOSD_TWO_WIRE_ADDRESS_MASK,
				`IOSD_SERIAL_PORT_STATUS_A,
				`IOSD_SERIAL_PORT_CONTROL_B,
				`IOSD_SERIAL_PORT_CONTROL_C,
				`IOSD_SERIAL_BAUD_LOW,
				`IOSD_SERIAL_BAUD_HIGH,
				`IOSD_SERIAL_DATA_BUFFER: begin
					is_mapped = 1'b1;
				end
				default: begin
					is_mapped = 1'b0;
				end
				endcase
			end
		end
	endfunction

	// True for the two ops that rewrite a single bit of a register.
	function alters_one_bit;
		input [2:0] op;
		begin
			alters_one_bit = (op == `IOSD_OP_SET_BIT) || (op == `IOSD_OP_CLEAR_BIT);
		end
	endfunction

	// Bits that clear when software writes a one to them.
	function [7:0] w1c_mask;
		input [7:0] a;
		begin
			case (a) // see RULE5
			`IOSD_TMR0_FLAGS: begin
				w1c_mask = `IOSD_W1C_TMR_FLAGS;
			end
			`IOSD_TMR1_FLAGS: begin
				w1c_mask = `IOSD_W1C_TMR1_FLAGS;
			end
			`IOSD_TMR2_FLAGS: begin
				w1c_mask = `IOSD_W1C_TMR_FLAGS;
			end
			`IOSD_PCHG_FLAGS: begin
				w1c_mask = `IOSD_W1C_PCHG_FLAGS;
			end
			`IOSD_EXT_FLAGS: begin
				w1c_mask = `IOSD_W1C_EXT_FLAGS;
			end
			`IOSD_CONVERTER_CONTROL_STATUS_A: begin
				w1c_mask = `IOSD_W1C_CONV_DONE;
			end
			`IOSD_TWO_WIRE_CONTROL: begin
				w1c_mask = `IOSD_W1C_TWI_INT;
			end
			`IOSD_SERIAL_PORT_STATUS_A: begin
				w1c_mask = `IOSD_W1C_SER_TXDONE;
			end
			default: begin
				w1c_mask = 8'h00;
			end
			endcase
		end
	endfunction

	// Bits owned by the peripheral; core writes leave them alone.
	function [7:0] ro_mask;
		input [7:0] a;
		begin
			case (a)
			`IOSD_CONVERTER_RESULT_LOW: begin
				ro_mask = `IOSD_RO_ALL;
			end
			`IOSD_ASYNC_TIMER_STATUS: begin
				ro_mask = `IOSD_RO_ASYNC_BUSY;
			end
			`IOSD_TWO_WIRE_STATUS: begin
				ro_mask = `IOSD_RO_TWI_STATE;
			end
			`IOSD_TWO_WIRE_CONTROL: begin
				ro_mask = `IOSD_RO_TWI_COLL;
			end
			`IOSD_SERIAL_PORT_STATUS_A: begin
				ro_mask = `IOSD_RO_SER_STAT;
			end
			`IOSD_SERIAL_PORT_CONTROL_B: begin
				ro_mask = `IOSD_RO_SER_RX9;
			end
			default: begin
				ro_mask = 8'h00;
			end
			endcase
		end
	endfunction

	// Reserved bits are never stored, so they always read as zero.
	// Dropping them here means a careless write of ones cannot set a bit that a later part may use.
	function [7:0] rsv_mask;
		input [7:0] a;
		begin
			case (a) // see RULE1
			`IOSD_PIN_CHANGE_MASK_1: begin
				rsv_mask = `IOSD_RSV_PCM1;
			end
			`IOSD_TIMER0_IRQ_ENABLES, `IOSD_TIMER2_IRQ_ENABLES: begin
				rsv_mask = `IOSD_RSV_TMSK;
			end
			`IOSD_TIMER1_IRQ_ENABLES: begin
				rsv_mask = `IOSD_RSV_TMSK1;
			end
			`IOSD_CONVERTER_INPUT_SELECT: begin
				rsv_mask = `IOSD_RSV_CONV_SEL;
			end
			`IOSD_DIGITAL_INPUT_DISABLE_1: begin
				rsv_mask = `IOSD_RSV_DIDIS1;
			end
			`IOSD_WIDE_TIMER_CONTROL_A, `IOSD_ASYNC_TIMER_CONTROL_A: begin
				rsv_mask = `IOSD_RSV_WT_CTLA;
			end
			`IOSD_WIDE_TIMER_CONTROL_B: begin
				rsv_mask = `IOSD_RSV_WT_CTLB;
			end
			`IOSD_WIDE_TIMER_CONTROL_C: begin
				rsv_mask = `IOSD_RSV_WT_CTLC;
			end
			`IOSD_ASYNC_TIMER_CONTROL_B: begin
				rsv_mask = `IOSD_RSV_AT_CTLB;
			end
			`IOSD_ASYNC_TIMER_STATUS: begin
				rsv_mask = `IOSD_RSV_AT_STAT;
			end
			`IOSD_TWO_WIRE_STATUS: begin
				rsv_mask = `IOSD_RSV_TWI_STAT;
			end
			`IOSD_TWO_WIRE_CONTROL: begin
				rsv_mask = `IOSD_RSV_TWI_CTL;
			end
			`IOSD_TWO_WIRE_ADDRESS_MASK: begin
				rsv_mask = `IOSD_RSV_TWI_AMSK;
			end
			`IOSD_SERIAL_BAUD_HIGH: begin
				rsv_mask = `IOSD_RSV_BAUD_HI;
			end
			default: begin
				rsv_mask = 8'h00;
			end
			endcase
		end
	endfunction

	// ****************************************
	// Register storage.
	// ****************************************
	// One byte per data-space address; the lowest 32 entries are never selected.
	// A flat array keeps the decode to a single index, at the cost of some unused storage.
	reg [7:0] regs_q [0:255];
	integer i;

	// ****************************************
	// Access decode.
	// ****************************************
	// Decode results for the access presented in this cycle.
	reg is_io_op;
	reg is_bit_op;
	reg is_skip_op;
	reg is_write;
	reg addr_ok;
	reg [7:0] dad;
	reg mapped;
	reg [7:0] cur;
	reg [7:0] wmask;
	reg [7:0] w1c;
	reg [7:0] bit_sel;
	reg [7:0] nv;
	reg do_write;
	reg refuse;
	reg [7:0] rd_val;

	// Classifies the access, checks its addressing range and forms the new value.
	always @* begin
		// Ops 0 to 5 carry a short I/O address, ops 6 and 7 a data-space address.
		is_io_op = (acc_op_i != `IOSD_OP_DATA_LOAD) && (acc_op_i != `IOSD_OP_DATA_STORE);
		is_bit_op = (acc_op_i == `IOSD_OP_SET_BIT) || (acc_op_i == `IOSD_OP_CLEAR_BIT)
			|| (acc_op_i == `IOSD_OP_SKIP_HIGH) || (acc_op_i == `IOSD_OP_SKIP_LOW);
		is_skip_op = (acc_op_i == `IOSD_OP_SKIP_HIGH) || (acc_op_i == `IOSD_OP_SKIP_LOW);
		is_write = (acc_op_i == `IOSD_OP_IO_WRITE) || (acc_op_i == `IOSD_OP_DATA_STORE)
			|| alters_one_bit(acc_op_i);

		// Short I/O ops never reach past 0x5F in data space, so the extended range stays load/store only.
		if (is_bit_op) begin
			addr_ok = (acc_addr_i[7:6] == 2'h0) && (acc_addr_i[5:0] <= `IOSD_BIT_IO_LAST); // see RULE3, RULE4
		end else if (is_io_op) begin
			addr_ok = (acc_addr_i[7:6] == 2'h0) && (acc_addr_i[5:0] <= `IOSD_SHORT_IO_LAST); // see RULE7, RULE9
		end else begin
			addr_ok = acc_addr_i >= `IOSD_DATA_IO_FIRST; // see RULE8, RULE9
		end

		// Every later lookup works on the data-space address.
		dad = is_io_op ? io_to_data(acc_addr_i[5:0]) : acc_addr_i;
		mapped = addr_ok && is_mapped(dad);
		cur = regs_q[dad];
		w1c = w1c_mask(dad);
		wmask = ~(rsv_mask(dad) | ro_mask(dad) | w1c);
		bit_sel = 8'h01 << acc_bit_i;

		if (acc_op_i == `IOSD_OP_SET_BIT) begin
			// Only the addressed bit moves; a one on a flag clears that flag alone.
			nv = ((w1c & bit_sel) != 8'h00) ? (cur & ~bit_sel) : (cur | (bit_sel & wmask)); // see RULE6
		end else if (acc_op_i == `IOSD_OP_CLEAR_BIT) begin
			// A zero written to a flag leaves it; ordinary bits clear.
			nv = cur & ~(bit_sel & wmask); // see RULE6
		end else begin
			nv = ((cur & ~wmask) | (acc_wdata_i & wmask)) & ~(acc_wdata_i & w1c); // see RULE5
		end

		// A refused access must leave storage and the write notice untouched.
		do_write = acc_valid_i && is_write && mapped;
		refuse = !addr_ok || (is_write && !mapped); // see RULE2
		// The write-only strobe register (wide timer control C) and reserved locations read as zero, with no side effects.
		if (!mapped || dad == `IOSD_WIDE_TIMER_CONTROL_C) begin
			rd_val = 8'h00; // see RULE10
		end else begin
			rd_val = cur;
		end
	end

	// ****************************************
	// Hardware-side updates.
	// ****************************************
	// Peripherals write by data-space address; unmapped addresses are ignored without notice.
	reg hw_hit;
	reg [7:0] hw_base;
	reg [7:0] hw_val;

	// A peripheral set folds onto a core write to the same address in the same cycle, so set beats clear.
	always @* begin
		hw_hit = (hw_load_i || hw_set_i) && is_mapped(hw_addr_i);
		hw_base = (do_write && hw_addr_i == dad) ? nv : regs_q[hw_addr_i];
		// A load replaces the whole byte; a set only adds ones to it.
		if (hw_load_i) begin
			hw_val = hw_data_i & ~rsv_mask(hw_addr_i);
		end else begin
			hw_val = (hw_base | hw_data_i) & ~rsv_mask(hw_addr_i);
		end
	end

	// Register array update; the hardware write is placed last so it takes precedence.
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			// Every location clears in reset; real start values are left to each peripheral.
			for (i = 0; i < 256; i = i + 1) begin
				regs_q[i] <= `IOSD_RST_VAL;
			end
		end else begin
			if (do_write) begin
				regs_q[dad] <= nv;
			end
			if (hw_hit) begin
				regs_q[hw_addr_i] <= hw_val;
			end
		end
	end

	// ****************************************
	// Answer to the core and write notice to peripherals.
	// ****************************************

	// One answer per access, one cycle after it is taken.
	// Every output is a flip-flop, so the core always samples a settled value.
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			ack_o <= 1'b0;
			rdata_o <= 8'h00;
			skip_o <= 1'b0;
			err_o <= 1'b0;
			wr_stb_o <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
		end else begin
			ack_o <= acc_valid_i;
			err_o <= acc_valid_i && refuse;
			// Refused reads and all writes answer with zero data.
			rdata_o <= (acc_valid_i && !is_write && addr_ok) ? rd_val : 8'h00;
			// The skip request is judged on the stored value before any write of this cycle lands.
			if (acc_valid_i && is_skip_op && addr_ok) begin
				skip_o <= (acc_op_i == `IOSD_OP_SKIP_HIGH) ? cur[acc_bit_i] : !cur[acc_bit_i]; // see RULE4
			end else begin
				skip_o <= 1'b0;
			end
			// Byte writes pass the raw written byte so strobe bits and flag clears reach peripherals; set and clear bit pass the new value.
			wr_stb_o <= do_write;
			if (do_write) begin
				wr_addr_o <= dad;
				wr_data_o <= alters_one_bit(acc_op_i) ? nv : acc_wdata_i;
			end
		end
	end

endmodule // iosd_decoder
`default_nettype wire

// ---- verification/iosd_decoder_monitor.sv ----
// Checker for the core access port of the register space decoder.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defs.vh"
module iosd_decoder_monitor (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic acc_valid_i,
	input wire logic [2:0] acc_op_i,
	input wire logic [7:0] acc_addr_i,
	input wire logic [7:0] acc_wdata_i,
	input wire logic ack_o,
	input wire logic skip_o,
	input wire logic err_o,
	input wire logic wr_stb_o,
	input wire logic [7:0] wr_addr_o,
	input wire logic [7:0] wr_data_o
);
	// ****************************************
	// Access timing, ranges and mapping.
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// Ops 0 to 5 carry a short I/O address, ops 6 and 7 a data-space address.
	wire logic io_op = (acc_op_i <= `IOSD_OP_SKIP_LOW);
	wire logic bit_op = (acc_op_i == `IOSD_OP_SET_BIT) || (acc_op_i == `IOSD_OP_CLEAR_BIT);
	wire logic skip_op = (acc_op_i == `IOSD_OP_SKIP_HIGH) || (acc_op_i == `IOSD_OP_SKIP_LOW);
	chk_ack_after_req: assert property (
		acc_valid_i |=> ack_o) else $error("no answer one cycle after an access");
	chk_ack_needs_req: assert property (
		!acc_valid_i |=> !ack_o) else $error("answer without an access");
	chk_bit_op_range: assert property (
		acc_valid_i && bit_op && acc_addr_i > 8'h1F |=> err_o && !wr_stb_o) else $error("bit op above low range taken");
	chk_short_io_range: assert property (
		acc_valid_i && io_op && acc_addr_i > 8'h3F |=> err_o) else $error("short access beyond its range taken");
	chk_data_low_refused: assert property (
		acc_valid_i && !io_op && acc_addr_i < 8'h20 |=> err_o) else $error("data access below offset taken");
	chk_refused_no_write: assert property (
		err_o |-> !wr_stb_o) else $error("refused access changed storage");
	chk_io_write_map: assert property (
		acc_valid_i && acc_op_i == `IOSD_OP_IO_WRITE ##1 wr_stb_o |-> wr_addr_o == $past(acc_addr_i) + 8'h20)
		else $error("short write landed at wrong data address");
	chk_store_addr: assert property (
		acc_valid_i && acc_op_i == `IOSD_OP_DATA_STORE ##1 wr_stb_o |-> wr_addr_o == $past(acc_addr_i))
		else $error("store landed at wrong address");
	chk_store_data: assert property (
		acc_valid_i && acc_op_i == `IOSD_OP_DATA_STORE ##1 wr_stb_o |-> wr_data_o == $past(acc_wdata_i))
		else $error("store notice carried wrong data");
	chk_skip_only_tests: assert property (
		acc_valid_i && !skip_op |=> !skip_o) else $error("skip requested by a non-test op");
	cover property (skip_o);
	cover property (err_o);
	cover property (wr_stb_o);
endmodule // iosd_decoder_monitor

bind iosd_decoder iosd_decoder_monitor i_mon (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.acc_valid_i(acc_valid_i),
	.acc_op_i(acc_op_i),
	.acc_addr_i(acc_addr_i),
	.acc_wdata_i(acc_wdata_i),
	.ack_o(ack_o),
	.skip_o(skip_o),
	.err_o(err_o),
	.wr_stb_o(wr_stb_o),
	.wr_addr_o(wr_addr_o),
	.wr_data_o(wr_data_o)
);
`default_nettype wire

// ---- verification/iosd_core_model.sv ----
// Behavioural processor core that issues register space accesses.
`timescale 1ns/1ps
`default_nettype none
module iosd_core_model (
	input wire logic clk_sys_i,
	input wire logic ack_o,
	input wire logic [7:0] rdata_o,
	input wire logic skip_o,
	input wire logic err_o,
	output var logic acc_valid_o = 1'b0,
	output var logic [2:0] acc_op_o = 3'h0,
	output var logic [7:0] acc_addr_o = 8'h00,
	output var logic [2:0] acc_bit_o = 3'h0,
	output var logic [7:0] acc_wdata_o = 8'h00
);
	// ****************************************
	// One access: a one-cycle request, then a bounded wait for the answer.
	// ****************************************
	// Address, bit and data are driven as the caller gives them; reserved bits and reserved addresses are not screened here.
	task automatic access(input logic [2:0] op, input logic [7:0] addr, input logic [2:0] bt,
		input logic [7:0] wd, output logic [7:0] rd, output logic sk, output logic er, output logic ok);
		int n;
		@(posedge clk_sys_i);
		acc_valid_o <= 1'b1;
		acc_op_o <= op;
		acc_addr_o <= addr;
		acc_bit_o <= bt;
		acc_wdata_o <= wd;
		@(posedge clk_sys_i);
		acc_valid_o <= 1'b0;
		acc_addr_o <= ~addr;
		acc_wdata_o <= ~wd;
		ok = 1'b0;
		// The answer stands for one cycle only, so it is taken at the edge that ends it, before outputs move on.
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge clk_sys_i);
			ok = (ack_o === 1'b1);
		end
		rd = rdata_o;
		sk = skip_o;
		er = err_o;
	endtask
endmodule // iosd_core_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking testbench for the register space decoder.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_defs.vh"
module tb_top;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic hw_load = 1'b0;
	logic hw_set = 1'b0;
	logic [7:0] hw_addr = 8'h00;
	logic [7:0] hw_data = 8'h00;
	wire acc_valid;
	wire [2:0] acc_op;
	wire [7:0] acc_addr;
	wire [2:0] acc_bit;
	wire [7:0] acc_wdata;
	wire ack;
	wire [7:0] rdata;
	wire skip;
	wire err;
	int mismatches = 0;
	int comparisons = 0;
	int i;
	logic [7:0] rd;
	logic sk, er, ok;
	logic [7:0] wa[7] = '{8'h6E, 8'h6F, 8'h6C, 8'h7F, 8'hBD, 8'hB8, 8'h82};
	logic [7:0] we[7] = '{8'h07, 8'h27, 8'h7F, 8'h03, 8'hFE, 8'hFF, 8'h00};

	// ****************************************
	// Clock, core model and decoder.
	// ****************************************
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	iosd_core_model i_core (.clk_sys_i(clk_sys_i), .ack_o(ack), .rdata_o(rdata), .skip_o(skip), .err_o(err),
		.acc_valid_o(acc_valid), .acc_op_o(acc_op), .acc_addr_o(acc_addr), .acc_bit_o(acc_bit),
		.acc_wdata_o(acc_wdata));
	iosd_decoder i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .acc_valid_i(acc_valid), .acc_op_i(acc_op),
		.acc_addr_i(acc_addr), .acc_bit_i(acc_bit), .acc_wdata_i(acc_wdata), .hw_load_i(hw_load),
		.hw_set_i(hw_set), .hw_addr_i(hw_addr), .hw_data_i(hw_data), .ack_o(ack), .rdata_o(rdata),
		.skip_o(skip), .err_o(err), .wr_stb_o(), .wr_addr_o(), .wr_data_o());

	// ****************************************
	// Shared tasks.
	// ****************************************
	task automatic close_out();
		$display("checks %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// A missing answer counts as a mismatch and ends the run at once.
	task automatic go(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
		i_core.access(op, a, b, w, rd, sk, er, ok);
		if (!ok) begin
			mismatches++;
			close_out();
		end
	endtask
	task automatic peek(input logic [7:0] a, input logic [7:0] exp);
		go(`IOSD_OP_DATA_LOAD, a, 3'h0, 8'h00);
		check({7'h00, er}, 8'h00, "load refused");
		check(rd, exp, "load data");
	endtask
	// Peripheral side strobe; the address is scrambled once the strobe drops.
	task automatic hw(input logic load, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		hw_load <= load;
		hw_set <= !load;
		hw_addr <= a;
		hw_data <= d;
		@(posedge clk_sys_i);
		hw_load <= 1'b0;
		hw_set <= 1'b0;
		hw_addr <= ~a;
	endtask

	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		repeat (6) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		for (i = 0; i < 7; i++) peek(wa[i], 8'h00);
		for (i = 0; i < 7; i++) begin
			go(`IOSD_OP_DATA_STORE, wa[i], 3'h0, 8'hFF);
			peek(wa[i], we[i]);
		end
		$display("test register table done");
		go(`IOSD_OP_DATA_STORE, 8'h71, 3'h0, 8'h55);
		check({7'h00, er}, 8'h01, "reserved store");
		peek(8'h71, 8'h00);
		go(`IOSD_OP_IO_READ, 8'h60, 3'h0, 8'h00);
		check({7'h00, er}, 8'h01, "short read of extended");
		go(`IOSD_OP_SET_BIT, 8'h20, 3'h0, 8'h00);
		check({7'h00, er}, 8'h01, "bit op above range");
		go(`IOSD_OP_DATA_LOAD, 8'h10, 3'h0, 8'h00);
		check({7'h00, er}, 8'h01, "load below offset");
		$display("test refusals done");
		go(`IOSD_OP_IO_WRITE, 8'h0A, 3'h0, 8'h5A);
		peek(8'h2A, 8'h5A);
		go(`IOSD_OP_DATA_STORE, 8'h5E, 3'h0, 8'h3C);
		go(`IOSD_OP_IO_READ, 8'h3E, 3'h0, 8'h00);
		check(rd, 8'h3C, "short read at top");
		go(`IOSD_OP_SET_BIT, 8'h0A, 3'h7, 8'h00);
		peek(8'h2A, 8'hDA);
		go(`IOSD_OP_CLEAR_BIT, 8'h0A, 3'h1, 8'h00);
		peek(8'h2A, 8'hD8);
		for (i = 0; i < 4; i++) begin
			go(i[1] ? `IOSD_OP_SKIP_LOW : `IOSD_OP_SKIP_HIGH, 8'h0A, i[0] ? 3'h0 : 3'h7, 8'h00);
			check({7'h00, sk}, {7'h00, i[0] ^ !i[1]}, "skip request");
		end
		$display("test mapping and bit access done");
		hw(1'b0, 8'h35, 8'h07);
		go(`IOSD_OP_DATA_STORE, 8'h35, 3'h0, 8'h00);
		peek(8'h35, 8'h07);
		go(`IOSD_OP_CLEAR_BIT, 8'h15, 3'h2, 8'h00);
		peek(8'h35, 8'h07);
		go(`IOSD_OP_SET_BIT, 8'h15, 3'h1, 8'h00);
		peek(8'h35, 8'h05);
		go(`IOSD_OP_DATA_STORE, 8'h35, 3'h0, 8'h01);
		peek(8'h35, 8'h04);
		// A flag set by hardware in the same cycle as a software clear of another flag.
		fork
			hw(1'b0, 8'h35, 8'h01);
			go(`IOSD_OP_DATA_STORE, 8'h35, 3'h0, 8'h04);
		join
		peek(8'h35, 8'h01);
		hw(1'b1, 8'h78, 8'h3C);
		go(`IOSD_OP_DATA_STORE, 8'h78, 3'h0, 8'hFF);
		peek(8'h78, 8'h3C);
		$display("test flags done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
